//--- bench/flash_link_chk.sv
/* link checker: framing, link clock shape and device turn-around.
   assumes: sits beside the link interface; host half period is 8. */
module flash_link_chk (
  // clock and reset
  input wire logic       clock,
  input wire logic       sys_rst,
  // link
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] d_io_o,
  input wire logic [3:0] d_io_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  logic       sclk_q_r;
  logic [5:0] rises_r;
  logic [5:0] rises_nxt;
  // sclk rises seen in the current frame
  assign rises_nxt = cs_n ? 6'h00 : rises_r + {5'h00, sclk & ~sclk_q_r};
  always_ff @(posedge clock)
  begin
    sclk_q_r <= sclk;
    rises_r  <= sys_rst ? 6'h00 : rises_nxt;
  end
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk) // still clock
    else $error("sclk moves outside a frame");
  AST_LEAD: assert property ($fell(cs_n) |-> !sclk [*8] ##1 !sclk [*8] ##1 sclk) // frame lead
    else $error("wrong lead before first sclk rise");
  AST_GAP: assert property ($rose(cs_n) |-> cs_n [*4]) // frame gap
    else $error("frames too close");
  AST_HALF: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk) // clock high
    else $error("sclk high time wrong");
  AST_HOST_HOLD: assert property (sclk && $past(sclk) |-> $stable(h_io_o)) // host data
    else $error("host data moves while sclk high");
  AST_DEV_HOLD: assert property (sclk && $past(sclk) |-> $stable(d_io_o)) // device data
    else $error("device data moves while sclk high");
  AST_RELEASE: assert property (cs_n && $past(cs_n) |-> d_io_oe == 4'h0) // device off
    else $error("device drives outside a frame");
  AST_LANES: assert property (d_io_oe != 4'h0 |-> d_io_oe == 4'h2 || d_io_oe == 4'hf)
    else $error("device drives unexpected lanes");
  AST_SINGLE_TURN: assert property (d_io_oe == 4'h2 |-> rises_r >= 6'h08) // after byte
    else $error("single answer before command end");
  AST_QUAD_TURN: assert property (d_io_oe == 4'hf |-> rises_r >= 6'h02) // after nibbles
    else $error("quad answer before command end");
  COV_FRAME: cover property ($fell(cs_n));
  COV_SINGLE: cover property (d_io_oe == 4'h2);
  COV_QUAD: cover property (d_io_oe == 4'hf);
endmodule // flash_link_chk

//--- bench/tb_flash_status_write_enable.sv
/* bench: controller and flash ends joined by the link, driven from the request side.
   assumes: host half period 8 gives a 64 ns link clock. */
module tb_flash_status_write_enable;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_ready;
  logic [7:0]  req_cmd = 8'h00;
  logic [2:0]  req_tx_n = 3'h0;
  logic [31:0] req_tx = 32'h0;
  logic [1:0]  req_rx_n = 2'h0;
  logic        req_quad = 1'b0;
  logic        quad = 1'b0;
  logic        pe_fail = 1'b0;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic [15:0] status_word;
  logic        four_wire_mode;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;
  flash_link_if link ();
  flash_host #(.HALF(8)) flash_host_inst (.link(link), .clock(clock), .sys_rst(sys_rst),
    .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_tx_n(req_tx_n),
    .req_tx(req_tx), .req_rx_n(req_rx_n), .req_quad(req_quad), .wp_level(1'b1),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  flash_device #(.SR_CYC(1500), .PE_CYC(1500)) flash_device_inst (.link(link), .clock(clock),
    .sys_rst(sys_rst), .pe_fail(pe_fail), .status_word(status_word),
    .four_wire_mode(four_wire_mode));
  flash_link_chk flash_link_chk_inst (.clock(clock), .sys_rst(sys_rst), .cs_n(link.cs_n),
    .sclk(link.sclk), .h_io_o(link.h_io_o), .d_io_o(link.d_io_o), .d_io_oe(link.d_io_oe));
  always #2 clock = ~clock;
  task automatic report_and_stop();
    if (fails == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      fails = fails + 1;
      report_and_stop();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one frame, request held for one clock, then wait for the answer
  task automatic send(input logic [7:0] c, input logic [2:0] n, input logic [31:0] tx,
                      input logic [1:0] rx);
    int i;
    @(posedge clock);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_tx_n <= n;
    req_tx <= tx;
    req_rx_n <= rx;
    req_quad <= quad;
    @(posedge clock);
    req_valid <= 1'b0;
    for (i = 0; i < 1000; i++)
    begin
      @(negedge clock);
      if (rsp_valid === 1'b1)
        break;
    end
    check({14'h0000, rsp_valid, req_ready}, 16'h0003); // frame answered
  endtask
  task automatic cmd1(input logic [7:0] c);
    send(c, 3'h0, 32'h0, 2'h0);
  endtask
  task automatic rd(input logic [7:0] c);
    send(c, 3'h0, 32'h0, 2'h1);
  endtask
  task automatic chk_sr(input logic [15:0] exp);
    rd(flash_sr_pkg::CMD_RD_LO);
    check({8'h00, rsp_data[7:0]}, {8'h00, exp[7:0]});
    rd(flash_sr_pkg::CMD_RD_HI);
    check({8'h00, rsp_data[7:0]}, {8'h00, exp[15:8]});
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 60; i++)
    begin
      rd(flash_sr_pkg::CMD_RD_LO);
      if (rsp_data[0] === 1'b0)
        break;
    end
  endtask
  task automatic do_reset();
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
  endtask
  task automatic t_latch();
    chk_sr(16'h0000); // defaults
    cmd1(flash_sr_pkg::CMD_LATCH_SET);
    chk_sr(16'h0002); // latch set
    cmd1(flash_sr_pkg::CMD_LATCH_CLR);
    chk_sr(16'h0000); // latch clear
  endtask
  task automatic t_volatile();
    cmd1(flash_sr_pkg::CMD_VOL_ARM); // arm before status write
    chk_sr(16'h0000); // no latch
    send(flash_sr_pkg::CMD_WR_SR, 3'h1, 32'h1c000000, 2'h0);
    chk_sr(16'h001c); // volatile update
    send(flash_sr_pkg::CMD_WR_SR, 3'h1, 32'h0, 2'h0);
    chk_sr(16'h001c); // write refused
  endtask
  task automatic t_sr_write();
    cmd1(flash_sr_pkg::CMD_LATCH_SET); // fresh latch
    send(flash_sr_pkg::CMD_WR_SR, 3'h2, 32'h00020000, 2'h0);
    rd(flash_sr_pkg::CMD_RD_LO);
    check(rsp_data & 16'h0003, 16'h0003); // busy read
    wait_idle();
    chk_sr(16'h0200); // write done
    check(status_word, 16'h0200); // status word
  endtask
  task automatic t_quad();
    cmd1(flash_sr_pkg::CMD_QPI_ON);
    quad = 1'b1;
    chk_sr(16'h0200); // quad read
    check({15'h0, four_wire_mode}, 16'h0001); // mode on
    cmd1(flash_sr_pkg::CMD_QPI_OFF);
    quad = 1'b0;
    chk_sr(16'h0200); // single read
    check({15'h0, four_wire_mode}, 16'h0000); // mode off
  endtask
  task automatic t_protect();
    cmd1(flash_sr_pkg::CMD_VOL_ARM);
    send(flash_sr_pkg::CMD_WR_SR, 3'h1, 32'h04000000, 2'h0);
    cmd1(flash_sr_pkg::CMD_LATCH_SET);
    send(flash_sr_pkg::CMD_PROG, 3'h4, 32'hff0000a5, 2'h0);
    chk_sr(16'h0604); // protected target
    cmd1(flash_sr_pkg::CMD_LATCH_SET);
    cmd1(flash_sr_pkg::CMD_CHIP_ERASE);
    chk_sr(16'h0606); // erase ignored
    send(flash_sr_pkg::CMD_PROG, 3'h4, 32'h000000a5, 2'h0);
    wait_idle();
    chk_sr(16'h0204); // fail cleared
    cmd1(flash_sr_pkg::CMD_LATCH_SET); // fresh latch
    send(flash_sr_pkg::CMD_SA_PROG, 3'h4, 32'h001400a5, 2'h0);
    chk_sr(16'h0604); // outside security areas
    cmd1(flash_sr_pkg::CMD_LATCH_SET);
    send(flash_sr_pkg::CMD_SA_PROG, 3'h4, 32'h001000a5, 2'h0);
    wait_idle();
    chk_sr(16'h0204); // security area one
  endtask
  task automatic t_suspend();
    cmd1(flash_sr_pkg::CMD_LATCH_SET);
    @(posedge clock);
    pe_fail <= 1'b1;
    send(flash_sr_pkg::CMD_SEC_ERASE, 3'h3, 32'h0, 2'h0);
    cmd1(flash_sr_pkg::CMD_SUSPEND);
    rd(flash_sr_pkg::CMD_RD_HI);
    check(rsp_data & 16'h0080, 16'h0080); // suspend set
    cmd1(flash_sr_pkg::CMD_RESUME);
    rd(flash_sr_pkg::CMD_RD_HI);
    check(rsp_data & 16'h0080, 16'h0000); // resume clears
    wait_idle();
    @(posedge clock);
    pe_fail <= 1'b0;
    chk_sr(16'h0604); // failed erase
  endtask
  task automatic t_lock();
    cmd1(flash_sr_pkg::CMD_VOL_ARM);
    send(flash_sr_pkg::CMD_WR_SR, 3'h2, 32'h04030000, 2'h0);
    cmd1(flash_sr_pkg::CMD_LATCH_SET);
    send(flash_sr_pkg::CMD_WR_SR, 3'h1, 32'h0, 2'h0);
    cmd1(flash_sr_pkg::CMD_LATCH_CLR);
    chk_sr(16'h0704); // locked status, fail kept
    do_reset();
    chk_sr(16'h0000); // power cycle
  endtask
  initial
  begin
    do_reset();
    t_latch();
    t_volatile();
    t_sr_write();
    t_quad();
    t_protect();
    t_suspend();
    t_lock();
    report_and_stop();
  end
endmodule // tb_flash_status_write_enable

//--- design/flash_device.sv
/*
  flash device end: status word, write latch and command decode.
  assumes: link frames are framed by cs_n; sclk only runs inside frames;
  sys_rst acts as a power cycle.
*/
module flash_device #(
  parameter int SR_CYC = flash_sr_pkg::SR_WRITE_CYC,
  parameter int PE_CYC = flash_sr_pkg::PE_CYC
) (
  // link
  flash_link_if.dev        link,
  // engine clock and power-cycle reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // array result
  input  wire logic        pe_fail,
  // state
  output logic      [15:0] status_word,
  output logic             four_wire_mode
);
  if (SR_CYC < 2 || SR_CYC > 65535 || PE_CYC < 2 || PE_CYC > 65535)
  begin : g_chk
    $error("cycle counts out of range");
  end

  // ---------------- link domain ----------------
  logic       first_r;
  logic [5:0] cnt_r;
  logic [7:0] sh_r;
  logic       qpi_r;
  logic       qpi_pend_r;
  logic [7:0] fr_cmd_r;
  logic [7:0] fr_dat_r [3];
  logic [5:0] fr_bits_r;
  logic       rd_r;
  logic       rd_hi_r;
  logic       oe_r;
  logic [2:0] ocnt_r;
  logic [7:0] out_r;
  logic [15:0] st_link;

  wire       lane4    = first_r ? qpi_pend_r : qpi_r;
  wire [5:0] cnt_base = first_r ? 6'h00 : cnt_r;
  wire [5:0] cnt_nxt  = (cnt_base > 6'h38) ? cnt_base : cnt_base + (lane4 ? 6'h04 : 6'h01);
  wire [7:0] sh_nxt   = lane4 ? {sh_r[3:0], link.io} : {sh_r[6:0], link.io[0]};
  wire       byte_done = (cnt_nxt[2:0] == 3'h0) && (cnt_nxt <= flash_sr_pkg::BITS_CMDA);
  wire [2:0] byte_idx  = cnt_nxt[5:3] - 3'h1;
  wire       cmd_done  = byte_done && (byte_idx == 3'h0);

  always_ff @(posedge link.sclk or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      first_r <= 1'b1;
      cnt_r   <= 6'h00;
      sh_r    <= 8'h00;
      rd_r    <= 1'b0;
      rd_hi_r <= 1'b0;
    end
    else
    begin
      first_r <= 1'b0;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      if (cmd_done)
      begin
        rd_r    <= (sh_nxt == flash_sr_pkg::CMD_RD_LO) || (sh_nxt == flash_sr_pkg::CMD_RD_HI);
        rd_hi_r <= (sh_nxt == flash_sr_pkg::CMD_RD_HI);
      end
    end
  end

  // frame record, read by the engine only after cs_n is seen high
  always_ff @(posedge link.sclk)
  begin
    fr_bits_r <= cnt_nxt;
    if (cmd_done)
      fr_cmd_r <= sh_nxt;
    if (byte_done && byte_idx != 3'h0)
      fr_dat_r[byte_idx[1:0] - 2'h1] <= sh_nxt;
  end

  // four-wire mode takes effect from the next frame
  always_ff @(posedge link.sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      qpi_r      <= 1'b0;
      qpi_pend_r <= 1'b0;
    end
    else
    begin
      if (first_r)
        qpi_r <= qpi_pend_r;
      if (cmd_done && sh_nxt == flash_sr_pkg::CMD_QPI_ON)
        qpi_pend_r <= 1'b1;
      else if (cmd_done && sh_nxt == flash_sr_pkg::CMD_QPI_OFF)
        qpi_pend_r <= 1'b0;
    end
  end
  assign four_wire_mode = qpi_r;

  sync2 #(.W(16), .RST_VAL(1'b0)) u_st_sync (
    .clock (link.sclk),
    .rst   (1'b0),
    .d     (status_word),
    .q     (st_link)
  );

  // status shifted out on falling edges, repeated per byte
  wire [2:0] olast = qpi_r ? 3'h1 : 3'h7;
  always_ff @(negedge link.sclk or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      oe_r   <= 1'b0;
      ocnt_r <= 3'h0;
      out_r  <= 8'h00;
    end
    else if (rd_r)
    begin
      oe_r <= 1'b1;
      if (!oe_r || ocnt_r == olast)
      begin
        out_r  <= rd_hi_r ? st_link[15:8] : st_link[7:0];
        ocnt_r <= 3'h0;
      end
      else
      begin
        out_r  <= qpi_r ? {out_r[3:0], 4'h0} : {out_r[6:0], 1'b0};
        ocnt_r <= ocnt_r + 3'h1;
      end
    end
  end

  // high nibble first, bit 7 on io3; single wire uses io1 only
  assign link.d_io_o  = qpi_r ? out_r[7:4] : {2'b00, out_r[7], 1'b0};
  assign link.d_io_oe = !oe_r ? 4'h0 : (qpi_r ? 4'hf : 4'h2);

  // ---------------- engine domain ----------------
  logic        cs_s;
  logic        wp_s;
  logic        cs_d_r;
  logic        busy_r;
  logic        wel_r;
  logic        fail_r;
  logic        susp_r;
  logic        volarm_r;
  logic        rsten_r;
  logic        pfail_r;
  flash_sr_pkg::op_t op_r;
  logic [15:0] tmr_r;
  logic [15:0] sw_r;
  logic [15:0] nv_r;
  logic [15:0] pend_r;

  sync2 #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
    .clock (clock),
    .rst   (sys_rst),
    .d     (link.cs_n),
    .q     (cs_s)
  );
  sync2 #(.W(1), .RST_VAL(1'b1)) u_wp_sync (
    .clock (clock),
    .rst   (sys_rst),
    .d     (link.io[2]),
    .q     (wp_s)
  );

  wire        cs_rise = cs_s && !cs_d_r;
  wire [7:0]  cmd     = fr_cmd_r;
  wire [5:0]  nb      = fr_bits_r;
  wire [23:0] addr    = {fr_dat_r[0], fr_dat_r[1], fr_dat_r[2]};
  wire        idle    = (op_r == flash_sr_pkg::OP_NONE);
  wire        exact1  = (nb == flash_sr_pkg::BITS_CMD);
  // lock modes; wp pin counts only while quad pins are off
  wire        lock_ok = !sw_r[8] && (!sw_r[7] || wp_s || sw_r[9]);
  // protect level counts 512k units from the top, inverted by bit 14
  wire [8:0]  thr     = 9'h100 - {1'b0, sw_r[6:2], 3'h0};
  wire        in_prot = (sw_r[6:2] != 5'h00) && ({1'b0, addr[23:16]} >= thr);
  wire        prot_hit = sw_r[14] ? !in_prot : in_prot;
  wire        sa_pfx  = (addr[15:10] == flash_sr_pkg::SA_PFX1) ||
                        (addr[15:10] == flash_sr_pkg::SA_PFX2) ||
                        (addr[15:10] == flash_sr_pkg::SA_PFX3);
  wire        sa_sel  = (addr[23:16] == 8'h00) && sa_pfx;
  wire [1:0]  sa_idx  = addr[13:12] - 2'h1;
  // a set one-time lock makes its area read-only
  wire        sa_bad  = !sa_sel || sw_r[flash_sr_pkg::OTP_LO + int'(sa_idx)];
  wire        is_sa   = (cmd == flash_sr_pkg::CMD_SA_ERASE) || (cmd == flash_sr_pkg::CMD_SA_PROG);
  wire        is_chip = (cmd == flash_sr_pkg::CMD_CHIP_ERASE) || (cmd == flash_sr_pkg::CMD_CHIP_ER2);
  wire        is_addr_pe = is_sa || (cmd == flash_sr_pkg::CMD_PROG) ||
                           (cmd == flash_sr_pkg::CMD_PROG_Q) ||
                           (cmd == flash_sr_pkg::CMD_PG_ERASE) ||
                           (cmd == flash_sr_pkg::CMD_SEC_ERASE) ||
                           (cmd == flash_sr_pkg::CMD_BLK_ERASE);
  wire        pe_ok_frm = is_chip ? exact1 : (is_addr_pe && nb >= flash_sr_pkg::BITS_CMDA);
  wire        pe_bad  = is_chip ? 1'b0 : (is_sa ? sa_bad : prot_hit);
  wire        is_rd   = (cmd == flash_sr_pkg::CMD_RD_LO) || (cmd == flash_sr_pkg::CMD_RD_HI);
  // status write data: 01h one or two bytes, 31h high byte
  wire        sr_frm  = (nb == flash_sr_pkg::BITS_CMD1) ||
                        (nb == flash_sr_pkg::BITS_CMD2 && cmd == flash_sr_pkg::CMD_WR_SR);
  wire        is_sr   = (cmd == flash_sr_pkg::CMD_WR_SR) || (cmd == flash_sr_pkg::CMD_WR_SR2);
  wire [15:0] sr_raw  = (cmd == flash_sr_pkg::CMD_WR_SR2) ? {fr_dat_r[0], sw_r[7:0]} :
                        (nb == flash_sr_pkg::BITS_CMD2) ? {fr_dat_r[1], fr_dat_r[0]} :
                        {sw_r[15:8], fr_dat_r[0]};
  wire [15:0] sr_new  = (sr_raw & flash_sr_pkg::WR_MASK) | (sw_r & ~flash_sr_pkg::WR_MASK) |
                        {2'b00, sw_r[13:11], 11'h000};
  wire        tmr_end = !idle && !susp_r && (tmr_r == 16'h0001);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      cs_d_r   <= 1'b1;
      busy_r   <= 1'b0;
      wel_r    <= 1'b0;
      fail_r   <= 1'b0;
      susp_r   <= 1'b0;
      volarm_r <= 1'b0;
      rsten_r  <= 1'b0;
      pfail_r  <= 1'b0;
      op_r     <= flash_sr_pkg::OP_NONE;
      tmr_r    <= 16'h0000;
      sw_r     <= flash_sr_pkg::STATUS_RST;
      nv_r     <= flash_sr_pkg::STATUS_RST;
      pend_r   <= flash_sr_pkg::STATUS_RST;
    end
    else
    begin
      cs_d_r <= cs_s;
      if (cs_rise)
      begin
        rsten_r <= (cmd == flash_sr_pkg::CMD_RST_EN);
        if (!is_rd)
          volarm_r <= 1'b0;
        case (cmd)
          flash_sr_pkg::CMD_LATCH_SET:
            if (idle && exact1)
              wel_r <= 1'b1;
          flash_sr_pkg::CMD_LATCH_CLR:
            if (idle && exact1)
              wel_r <= 1'b0;
          flash_sr_pkg::CMD_VOL_ARM:
            if (idle && exact1)
              volarm_r <= 1'b1;
          // suspend a running program or erase
          flash_sr_pkg::CMD_SUSPEND:
            if (op_r == flash_sr_pkg::OP_PE && !susp_r)
            begin
              susp_r <= 1'b1;
              busy_r <= 1'b0;
            end
          flash_sr_pkg::CMD_RESUME:
            if (susp_r)
            begin
              susp_r <= 1'b0;
              busy_r <= 1'b1;
            end
          // soft reset aborts and reloads volatile copies
          flash_sr_pkg::CMD_RST:
            if (rsten_r)
            begin
              if (op_r == flash_sr_pkg::OP_PE)
                fail_r <= 1'b1;
              op_r   <= flash_sr_pkg::OP_NONE;
              busy_r <= 1'b0;
              wel_r  <= 1'b0;
              susp_r <= 1'b0;
              sw_r   <= nv_r;
            end
          flash_sr_pkg::CMD_WR_CFG,
          flash_sr_pkg::CMD_WR_EXT:
            if (idle && wel_r && nb == flash_sr_pkg::BITS_CMD1)
              wel_r <= 1'b0;
          default:
          begin
            // status write needs latch or volatile arm and an open lock
            if (is_sr && sr_frm && idle && lock_ok)
            begin
              if (volarm_r)
                sw_r <= sr_new;
              else if (wel_r)
              begin
                busy_r <= 1'b1;
                op_r   <= flash_sr_pkg::OP_SR;
                tmr_r  <= 16'(SR_CYC);
                pend_r <= sr_new;
              end
            end
            if (pe_ok_frm && idle && wel_r && !(is_chip && sw_r[6:2] != 5'h00))
            begin
              if (pe_bad)
              begin
                fail_r <= 1'b1;
                wel_r  <= 1'b0;
              end
              else
              begin
                busy_r  <= 1'b1;
                op_r    <= flash_sr_pkg::OP_PE;
                tmr_r   <= 16'(PE_CYC);
                pfail_r <= 1'b0;
              end
            end
          end
        endcase
      end
      else if (tmr_end)
      begin
        // cycle done: busy and latch drop
        op_r   <= flash_sr_pkg::OP_NONE;
        busy_r <= 1'b0;
        wel_r  <= 1'b0;
        if (op_r == flash_sr_pkg::OP_SR)
        begin
          sw_r <= pend_r;
          nv_r <= pend_r;
        end
        else
          // fail follows the result of the last operation
          fail_r <= pfail_r || pe_fail;
      end
      else if (!idle && !susp_r)
      begin
        tmr_r <= tmr_r - 16'h0001;
        if (pe_fail)
          pfail_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      status_word <= flash_sr_pkg::STATUS_RST;
    else
      status_word <= {susp_r, sw_r[14:11], fail_r, sw_r[9:2], wel_r, busy_r};
  end
endmodule // flash_device

//--- design/flash_host.sv
/*
  flash controller end: runs one command frame per request.
  assumes: req_quad matches the device's four-wire mode; sclk is made here.
*/
module flash_host #(
  parameter int HALF = flash_sr_pkg::SCLK_HALF
) (
  // link
  flash_link_if.host        link,
  // clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // request
  input  wire logic         req_valid,
  output logic              req_ready,
  input  wire logic [7:0]   req_cmd,
  input  wire logic [2:0]   req_tx_n,
  input  wire logic [31:0]  req_tx,
  input  wire logic [1:0]   req_rx_n,
  input  wire logic         req_quad,
  input  wire logic         wp_level,
  // answer
  output logic              rsp_valid,
  output logic      [15:0]  rsp_data
);
  if (HALF < 2 || HALF > 255)
  begin : g_chk
    $error("HALF out of range");
  end

  flash_sr_pkg::host_state_t st_r;
  logic [7:0]  div_r;
  logic [39:0] sh_r;
  logic [15:0] rx_r;
  logic [6:0]  step_r;
  logic [6:0]  total_r;
  logic [6:0]  txs_r;
  logic        quad_r;
  logic        cs_n_r;
  logic        sclk_r;
  logic [3:0]  io_s;

  sync2 #(.W(4), .RST_VAL(1'b1)) u_io_sync (
    .clock (clock),
    .rst   (sys_rst),
    .d     (link.io),
    .q     (io_s)
  );

  wire       half_end = (div_r == 8'(HALF - 1));
  wire [3:0] nbytes   = 4'h1 + {1'b0, req_tx_n} + {2'b00, req_rx_n};
  wire [3:0] ntx      = 4'h1 + {1'b0, req_tx_n};
  wire [6:0] step_nxt = step_r + 7'h01;
  wire       in_tx    = (step_r < txs_r);
  assign req_ready = (st_r == flash_sr_pkg::H_IDLE);

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_r      <= flash_sr_pkg::H_IDLE;
      div_r     <= 8'h00;
      sh_r      <= 40'h0;
      rx_r      <= 16'h0000;
      step_r    <= 7'h00;
      total_r   <= 7'h00;
      txs_r     <= 7'h00;
      quad_r    <= 1'b0;
      cs_n_r    <= 1'b1;
      sclk_r    <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (st_r)
        flash_sr_pkg::H_IDLE:
          if (req_valid)
          begin
            sh_r    <= {req_cmd, req_tx};
            quad_r  <= req_quad;
            // two clocks per byte in four-wire mode
            total_r <= req_quad ? {2'b00, nbytes, 1'b0} : {nbytes, 3'h0};
            txs_r   <= req_quad ? {2'b00, ntx, 1'b0} : {ntx, 3'h0};
            step_r  <= 7'h00;
            div_r   <= 8'h00;
            cs_n_r  <= 1'b0;
            st_r    <= flash_sr_pkg::H_SETUP;
          end
        flash_sr_pkg::H_SETUP:
        begin
          div_r <= half_end ? 8'h00 : div_r + 8'h01;
          if (half_end)
            st_r <= flash_sr_pkg::H_SHIFT;
        end
        flash_sr_pkg::H_SHIFT:
        begin
          div_r <= half_end ? 8'h00 : div_r + 8'h01;
          if (half_end)
          begin
            sclk_r <= !sclk_r;
            if (sclk_r)
            begin
              // falling edge: sample reply, present next bits
              rx_r   <= quad_r ? {rx_r[11:0], io_s} : {rx_r[14:0], io_s[1]};
              sh_r   <= quad_r ? {sh_r[35:0], 4'h0} : {sh_r[38:0], 1'b0};
              step_r <= step_nxt;
              if (step_nxt == total_r)
                st_r <= flash_sr_pkg::H_END;
            end
          end
        end
        flash_sr_pkg::H_END:
        begin
          cs_n_r <= 1'b1;
          div_r  <= half_end ? 8'h00 : div_r + 8'h01;
          if (half_end)
          begin
            rsp_valid <= 1'b1;
            rsp_data  <= rx_r;
            st_r      <= flash_sr_pkg::H_IDLE;
          end
        end
        default:
          st_r <= flash_sr_pkg::H_IDLE;
      endcase
    end
  end

  // frame order is the user's; io2/io3 hold wp and hold levels in single mode
  assign link.cs_n    = cs_n_r;
  assign link.sclk    = sclk_r;
  assign link.h_io_o  = quad_r ? sh_r[39:36] : {1'b1, wp_level, 1'b0, sh_r[39]};
  assign link.h_io_oe = cs_n_r ? 4'h0 : (quad_r ? (in_tx ? 4'hf : 4'h0) : 4'hd);
endmodule // flash_host

//--- design/flash_link_if.sv
/*
  serial/quad link between flash controller and flash device.
  assumes: io lines are pulled up when nobody drives them.
*/
interface flash_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  // resolved wire level, device wins, pull-up otherwise
  assign io = (d_io_oe & d_io_o) | (~d_io_oe & h_io_oe & h_io_o) | (~d_io_oe & ~h_io_oe);

  modport host (output cs_n, output sclk, output h_io_o, output h_io_oe, input io);
  modport dev  (input cs_n, input sclk, input io, output d_io_o, output d_io_oe);
endinterface

//--- design/flash_sr_pkg.sv
/*
  constants shared by both ends of the serial flash status link.
  assumes: nothing beyond a systemverilog compiler.
*/
package flash_sr_pkg;
  // command codes
  localparam logic [7:0] CMD_LATCH_SET  = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLR  = 8'h04;
  localparam logic [7:0] CMD_VOL_ARM    = 8'h50;
  localparam logic [7:0] CMD_RD_LO      = 8'h05;
  localparam logic [7:0] CMD_RD_HI      = 8'h35;
  localparam logic [7:0] CMD_WR_SR      = 8'h01;
  localparam logic [7:0] CMD_WR_SR2     = 8'h31;
  localparam logic [7:0] CMD_WR_CFG     = 8'h11;
  localparam logic [7:0] CMD_WR_EXT     = 8'hc5;
  localparam logic [7:0] CMD_PROG       = 8'h02;
  localparam logic [7:0] CMD_PROG_Q     = 8'h32;
  localparam logic [7:0] CMD_PG_ERASE   = 8'h81;
  localparam logic [7:0] CMD_SEC_ERASE  = 8'h20;
  localparam logic [7:0] CMD_BLK_ERASE  = 8'hd8;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h60;
  localparam logic [7:0] CMD_CHIP_ER2   = 8'hc7;
  localparam logic [7:0] CMD_SA_ERASE   = 8'h44;
  localparam logic [7:0] CMD_SA_PROG    = 8'h42;
  localparam logic [7:0] CMD_SUSPEND    = 8'h75;
  localparam logic [7:0] CMD_RESUME     = 8'h7a;
  localparam logic [7:0] CMD_RST_EN     = 8'h66;
  localparam logic [7:0] CMD_RST        = 8'h99;
  localparam logic [7:0] CMD_QPI_ON     = 8'h38;
  localparam logic [7:0] CMD_QPI_OFF    = 8'hff;
  // status word layout
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [15:0] WR_MASK    = 16'h7bfc;
  localparam int          OTP_LO     = 11;
  // security area prefixes on address bits 15:10
  localparam logic [5:0] SA_PFX1 = 6'h04;
  localparam logic [5:0] SA_PFX2 = 6'h08;
  localparam logic [5:0] SA_PFX3 = 6'h0c;
  // frame bit counts
  localparam logic [5:0] BITS_CMD   = 6'h08;
  localparam logic [5:0] BITS_CMD1  = 6'h10;
  localparam logic [5:0] BITS_CMD2  = 6'h18;
  localparam logic [5:0] BITS_CMDA  = 6'h20;
  // self-timed cycle counts and link clock half period
  localparam int SR_WRITE_CYC = 64;
  localparam int PE_CYC       = 256;
  localparam int SCLK_HALF    = 8;

  typedef enum logic [1:0] {OP_NONE = 2'b00, OP_SR = 2'b01, OP_PE = 2'b10} op_t;
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_SHIFT = 2'b10,
    H_END   = 2'b11
  } host_state_t;
endpackage

//--- design/sync2.sv
/*
  two-flop level synchroniser.
  assumes: d is a level that stays stable for several destination clocks.
*/
module sync2 #(
  parameter int   W       = 1,
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s1_r <= {W{RST_VAL}};
      q    <= {W{RST_VAL}};
    end
    else
    begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule // sync2
